// ===== acr_defines.svh
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

`define ACR_REG_RES_HI 3'h0
`define ACR_REG_RES_LO 3'h1
`define ACR_REG_CFG0 3'h2
`define ACR_REG_CFG1 3'h3
`define ACR_REG_CFG2 3'h4
`define ACR_REG_CFG3 3'h5
`define ACR_REG_CFG4 3'h6
`define ACR_REG_CFG5 3'h7

`define ACR_CFG0_START 7
`define ACR_CFG0_NEL_HI 6
`define ACR_CFG0_NEL_LO 5
`define ACR_CFG0_OSR_HI 4
`define ACR_CFG0_OSR_LO 2
`define ACR_CFG0_CONT 1
`define ACR_CFG1_MBIAS_HI 7
`define ACR_CFG1_MBIAS_LO 6
`define ACR_CFG1_ABIAS_HI 5
`define ACR_CFG1_ABIAS_LO 4
`define ACR_CFG1_EN_HI 3
`define ACR_CFG1_EN_LO 0
`define ACR_CFG2_FS_HI 7
`define ACR_CFG2_FS_LO 6
`define ACR_CFG2_G2_HI 5
`define ACR_CFG2_G2_LO 4
`define ACR_CFG2_OFF2_HI 3
`define ACR_CFG2_OFF2_LO 0
`define ACR_CFG3_G1 7
`define ACR_CFG3_G3_HI 6
`define ACR_CFG3_G3_LO 0
`define ACR_CFG4_OFF3_HI 6
`define ACR_CFG4_OFF3_LO 0
`define ACR_CFG5_BUSY 7
`define ACR_CFG5_DEF 6
`define ACR_CFG5_AMUX_HI 5
`define ACR_CFG5_AMUX_LO 1
`define ACR_CFG5_VMUX 0

`define ACR_DEF_NEL 2'h1
`define ACR_DEF_OSR 3'h2
`define ACR_DEF_CONT 1'h0
`define ACR_DEF_MBIAS 2'h3
`define ACR_DEF_ABIAS 2'h3
`define ACR_DEF_EN 4'h1
`define ACR_DEF_FS 2'h3
`define ACR_DEF_G1 1'h0
`define ACR_DEF_G2 2'h0
`define ACR_DEF_OFF2 4'h0
`define ACR_DEF_G3 7'h0c
`define ACR_DEF_OFF3 7'h00
`define ACR_DEF_AMUX 5'h00
`define ACR_DEF_VMUX 1'h0

`define ACR_SYS_CLK_MHZ 100
`define ACR_FS3_NS 2000
`define ACR_FS2_NS 4000
`define ACR_FS1_NS 8000
`define ACR_FS0_NS 16000
`define ACR_OSC_START_US 450
`define ACR_OSR_BASE_LOG 3
`define ACR_RES_FRAC 15
`define ACR_RES_MAX 16'h7fff
`define ACR_RES_MIN 16'h8000

`endif

// ===== acr_pkg.sv
`default_nettype none
package acr_pkg;
  typedef enum logic [2:0] {
    ACR_IDLE = 3'b001,
    ACR_ELEM = 3'b010,
    ACR_FINAL = 3'b100
  } acr_state_t;
  typedef logic [7:0] acr_byte_t;
endpackage
`default_nettype wire

// ===== acr_chain_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "acr_defines.svh"
module acr_chain_regs #(
  parameter int unsigned OSC_START_CYCLES = `ACR_OSC_START_US * `ACR_SYS_CLK_MHZ
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire acr_pkg::acr_byte_t reg_wdata_i,
  output acr_pkg::acr_byte_t reg_rdata_o,
  input wire logic wake_i,
  input wire logic mod_bit_i,
  output logic [1:0] elem_conv_count_sel_o,
  output logic [2:0] oversample_ratio_sel_o,
  output logic [1:0] modulator_bias_scale_o,
  output logic [1:0] amplifier_bias_scale_o,
  output logic [3:0] stage_enable_o,
  output logic [1:0] sample_rate_sel_o,
  output logic stage1_gain_o,
  output logic [1:0] stage2_gain_o,
  output logic [3:0] stage2_offset_o,
  output logic [6:0] stage3_gain_o,
  output logic [6:0] stage3_offset_o,
  output logic [4:0] input_sel_o,
  output logic ref_sel_o,
  output logic busy_o,
  output logic chop_o,
  output logic sample_tick_o,
  output logic conv_done_o,
  output logic osc_ready_o
);
  import acr_pkg::*;

  localparam logic [10:0] FS3_CYC = 11'((`ACR_FS3_NS * `ACR_SYS_CLK_MHZ) / 1000);
  localparam logic [10:0] FS2_CYC = 11'((`ACR_FS2_NS * `ACR_SYS_CLK_MHZ) / 1000);
  localparam logic [10:0] FS1_CYC = 11'((`ACR_FS1_NS * `ACR_SYS_CLK_MHZ) / 1000);
  localparam logic [10:0] FS0_CYC = 11'((`ACR_FS0_NS * `ACR_SYS_CLK_MHZ) / 1000);

  logic [1:0] nel_sel;
  logic [2:0] osr_sel;
  logic cont;
  logic [1:0] mbias;
  logic [1:0] abias;
  logic [3:0] enable;
  logic [1:0] fs_sel;
  logic g1;
  logic [1:0] g2;
  logic [3:0] off2;
  logic [6:0] g3;
  logic [6:0] off3;
  logic [4:0] amux;
  logic vmux;
  logic [15:0] result;
  logic pending;
  acr_state_t state;
  logic [1:0] cur_nel;
  logic [2:0] cur_osr;
  logic [1:0] cur_fs;
  logic [10:0] div_cnt;
  logic [10:0] samp_cnt;
  logic [3:0] elem_idx;
  logic signed [21:0] acc;
  logic [31:0] wake_cnt;
  logic tick;
  logic [15:0] next_result;

  wire logic wr_cfg0 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG0);
  wire logic wr_cfg1 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG1);
  wire logic wr_cfg2 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG2);
  wire logic wr_cfg3 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG3);
  wire logic wr_cfg4 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG4);
  wire logic wr_cfg5 = reg_wr_i && (reg_addr_i == `ACR_REG_CFG5);
  wire logic def_hit = wr_cfg5 && reg_wdata_i[`ACR_CFG5_DEF];
  wire logic req_set = wr_cfg0 && !def_hit &&
    (reg_wdata_i[`ACR_CFG0_START] || reg_wdata_i[`ACR_CFG0_CONT]);
  wire logic osc_ready = (wake_cnt == 32'h0);
  wire logic launch = osc_ready &&
    (def_hit || (state == ACR_IDLE && (pending || cont)));
  wire logic [10:0] osr_val = 11'h1 << (`ACR_OSR_BASE_LOG + cur_osr);
  wire logic [3:0] nel_last = 4'((4'h1 << cur_nel) - 4'h1);

  // Configuration fields; restore-defaults overrides any write
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nel_sel <= `ACR_DEF_NEL;
      osr_sel <= `ACR_DEF_OSR;
      cont <= `ACR_DEF_CONT;
    end else if (def_hit) begin
      nel_sel <= `ACR_DEF_NEL;
      osr_sel <= `ACR_DEF_OSR;
      cont <= `ACR_DEF_CONT;
    end else if (wr_cfg0) begin
      nel_sel <= reg_wdata_i[`ACR_CFG0_NEL_HI:`ACR_CFG0_NEL_LO];
      osr_sel <= reg_wdata_i[`ACR_CFG0_OSR_HI:`ACR_CFG0_OSR_LO];
      cont <= reg_wdata_i[`ACR_CFG0_CONT];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mbias <= `ACR_DEF_MBIAS;
      abias <= `ACR_DEF_ABIAS;
      enable <= `ACR_DEF_EN;
    end else if (def_hit) begin
      mbias <= `ACR_DEF_MBIAS;
      abias <= `ACR_DEF_ABIAS;
      enable <= `ACR_DEF_EN;
    end else if (wr_cfg1) begin
      mbias <= reg_wdata_i[`ACR_CFG1_MBIAS_HI:`ACR_CFG1_MBIAS_LO];
      abias <= reg_wdata_i[`ACR_CFG1_ABIAS_HI:`ACR_CFG1_ABIAS_LO];
      enable <= reg_wdata_i[`ACR_CFG1_EN_HI:`ACR_CFG1_EN_LO];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_sel <= `ACR_DEF_FS;
      g2 <= `ACR_DEF_G2;
      off2 <= `ACR_DEF_OFF2;
    end else if (def_hit) begin
      fs_sel <= `ACR_DEF_FS;
      g2 <= `ACR_DEF_G2;
      off2 <= `ACR_DEF_OFF2;
    end else if (wr_cfg2) begin
      fs_sel <= reg_wdata_i[`ACR_CFG2_FS_HI:`ACR_CFG2_FS_LO];
      g2 <= reg_wdata_i[`ACR_CFG2_G2_HI:`ACR_CFG2_G2_LO];
      off2 <= reg_wdata_i[`ACR_CFG2_OFF2_HI:`ACR_CFG2_OFF2_LO];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      g1 <= `ACR_DEF_G1;
      g3 <= `ACR_DEF_G3;
      off3 <= `ACR_DEF_OFF3;
    end else if (def_hit) begin
      g1 <= `ACR_DEF_G1;
      g3 <= `ACR_DEF_G3;
      off3 <= `ACR_DEF_OFF3;
    end else begin
      if (wr_cfg3) begin
        g1 <= reg_wdata_i[`ACR_CFG3_G1];
        g3 <= reg_wdata_i[`ACR_CFG3_G3_HI:`ACR_CFG3_G3_LO];
      end
      if (wr_cfg4) begin
        off3 <= reg_wdata_i[`ACR_CFG4_OFF3_HI:`ACR_CFG4_OFF3_LO];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      amux <= `ACR_DEF_AMUX;
      vmux <= `ACR_DEF_VMUX;
    end else if (def_hit) begin
      amux <= `ACR_DEF_AMUX;
      vmux <= `ACR_DEF_VMUX;
    end else if (wr_cfg5) begin
      amux <= reg_wdata_i[`ACR_CFG5_AMUX_HI:`ACR_CFG5_AMUX_LO];
      vmux <= reg_wdata_i[`ACR_CFG5_VMUX];
    end
  end

  // Oscillator start-up hold after wake
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_cnt <= 32'h0;
    end else if (wake_i) begin
      wake_cnt <= OSC_START_CYCLES;
    end else if (wake_cnt != 32'h0) begin
      wake_cnt <= wake_cnt - 32'h1;
    end
  end

  // Queued single request; a new request wins over the launch clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= 1'b0;
    end else if (req_set) begin
      pending <= 1'b1;
    end else if (launch || def_hit) begin
      pending <= 1'b0;
    end
  end

  // Sample period divider, realigned at each launch
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 11'h0;
      tick <= 1'b0;
    end else if (launch || state == ACR_IDLE) begin
      div_cnt <= 11'h0;
      tick <= 1'b0;
    end else begin
      case (cur_fs)
        2'h3: tick <= (div_cnt == FS3_CYC - 11'h2);
        2'h2: tick <= (div_cnt == FS2_CYC - 11'h2);
        2'h1: tick <= (div_cnt == FS1_CYC - 11'h2);
        default: tick <= (div_cnt == FS0_CYC - 11'h2);
      endcase
      div_cnt <= tick ? 11'h0 : div_cnt + 11'h1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ACR_IDLE;
      cur_nel <= `ACR_DEF_NEL;
      cur_osr <= `ACR_DEF_OSR;
      cur_fs <= `ACR_DEF_FS;
      samp_cnt <= 11'h0;
      elem_idx <= 4'h0;
      acc <= 22'sh0;
      chop_o <= 1'b0;
      conv_done_o <= 1'b0;
      result <= 16'h0;
    end else begin
      conv_done_o <= 1'b0;
      if (launch) begin
        state <= ACR_ELEM;
        cur_nel <= def_hit ? `ACR_DEF_NEL : nel_sel;
        cur_osr <= def_hit ? `ACR_DEF_OSR : osr_sel;
        cur_fs <= def_hit ? `ACR_DEF_FS : fs_sel;
        samp_cnt <= 11'h0;
        elem_idx <= 4'h0;
        acc <= 22'sh0;
        chop_o <= 1'b0;
      end else if (tick) begin
        case (state)
          ACR_ELEM: begin
            if (samp_cnt != 11'h0) begin
              // Chopped phases are flipped back before summing
              acc <= (mod_bit_i ^ chop_o) ? acc + 22'sh1 : acc - 22'sh1;
            end
            if (samp_cnt == osr_val) begin
              samp_cnt <= 11'h0;
              chop_o <= ~chop_o;
              elem_idx <= elem_idx + 4'h1;
              if (elem_idx == nel_last) begin
                state <= ACR_FINAL;
              end
            end else begin
              samp_cnt <= samp_cnt + 11'h1;
            end
          end
          ACR_FINAL: begin
            result <= next_result;
            conv_done_o <= 1'b1;
            state <= ACR_IDLE;
          end
          default: begin
            state <= ACR_IDLE;
          end
        endcase
      end
    end
  end

  // Mean of all integrations scaled to 16 bits, saturated
  always_comb begin
    logic signed [36:0] scaled;
    logic [4:0] shift;
    shift = 5'(cur_nel) + 5'(cur_osr) + 5'(`ACR_OSR_BASE_LOG);
    scaled = (37'(acc) <<< `ACR_RES_FRAC) >>> shift;
    if (scaled > 37'sh0_0000_7fff) begin
      next_result = `ACR_RES_MAX;
    end else if (scaled < -37'sh0_0000_8000) begin
      next_result = `ACR_RES_MIN;
    end else begin
      next_result = scaled[15:0];
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `ACR_REG_RES_HI: reg_rdata_o <= result[15:8];
        `ACR_REG_RES_LO: reg_rdata_o <= result[7:0];
        `ACR_REG_CFG0: reg_rdata_o <= {1'b0, nel_sel, osr_sel, cont, 1'b0};
        `ACR_REG_CFG1: reg_rdata_o <= {mbias, abias, enable};
        `ACR_REG_CFG2: reg_rdata_o <= {fs_sel, g2, off2};
        `ACR_REG_CFG3: reg_rdata_o <= {g1, g3};
        `ACR_REG_CFG4: reg_rdata_o <= {1'b0, off3};
        `ACR_REG_CFG5: reg_rdata_o <= {state != ACR_IDLE, 1'b0, amux, vmux};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      osc_ready_o <= 1'b1;
      sample_tick_o <= 1'b0;
    end else begin
      busy_o <= launch || (state != ACR_IDLE && !(state == ACR_FINAL && tick));
      osc_ready_o <= osc_ready && !wake_i;
      sample_tick_o <= tick;
    end
  end

  assign elem_conv_count_sel_o = nel_sel;
  assign oversample_ratio_sel_o = osr_sel;
  assign modulator_bias_scale_o = mbias;
  assign amplifier_bias_scale_o = abias;
  assign stage_enable_o = enable;
  assign sample_rate_sel_o = fs_sel;
  assign stage1_gain_o = g1;
  assign stage2_gain_o = g2;
  assign stage2_offset_o = off2;
  assign stage3_gain_o = g3;
  assign stage3_offset_o = off3;
  assign input_sel_o = amux;
  assign ref_sel_o = vmux;
endmodule // acr_chain_regs
`default_nettype wire

// ===== acr_chain_properties.sv
`timescale 1ns/1ns
`default_nettype none
module acr_chain_props #(
  parameter int unsigned OSC_START_CYCLES = 45000
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire acr_pkg::acr_byte_t reg_wdata_i,
  input wire acr_pkg::acr_byte_t reg_rdata_o,
  input wire logic [1:0] elem_conv_count_sel_o,
  input wire logic [2:0] oversample_ratio_sel_o,
  input wire logic [1:0] sample_rate_sel_o,
  input wire logic stage1_gain_o,
  input wire logic [6:0] stage3_gain_o,
  input wire logic busy_o,
  input wire logic chop_o,
  input wire logic sample_tick_o,
  input wire logic conv_done_o,
  input wire logic osc_ready_o
);
  import acr_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned hold_cnt;
  // Length of the current oscillator hold
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= osc_ready_o ? 0 : hold_cnt + 1;
    end
  end
  sequence s_def;
    reg_wr_i && reg_addr_i == 3'h7 && reg_wdata_i[6];
  endsequence
  sequence s_launch;
    $rose(busy_o);
  endsequence
  start_reads_zero_a: assert property (
    reg_rd_i && reg_addr_i == 3'h2 |=> !reg_rdata_o[7])
    else $error("start bit read back set");
  busy_read_a: assert property (
    reg_rd_i && reg_addr_i == 3'h7 |=> reg_rdata_o[7] == $past(busy_o))
    else $error("busy bit mismatch");
  gain_write_a: assert property (
    reg_wr_i && reg_addr_i == 3'h5 |=> {stage1_gain_o, stage3_gain_o} == $past(reg_wdata_i))
    else $error("gain fields not written");
  def_load_a: assert property (
    s_def |=> {elem_conv_count_sel_o, oversample_ratio_sel_o, sample_rate_sel_o} == 7'h2b)
    else $error("defaults not loaded");
  done_pulse_a: assert property (conv_done_o |=> !conv_done_o)
    else $error("done pulse too long");
  chop_first_a: assert property (s_launch |-> !chop_o)
    else $error("chop phase not zero at start");
  osc_gate_a: assert property (s_launch |-> osc_ready_o)
    else $error("conversion during oscillator hold");
  osc_len_a: assert property (
    $rose(osc_ready_o) |->
      hold_cnt + 2 >= OSC_START_CYCLES && hold_cnt <= OSC_START_CYCLES + 2)
    else $error("oscillator hold length wrong");
  tick_gap_a: assert property (sample_tick_o |=> !sample_tick_o [*8])
    else $error("sample ticks too close");
endmodule // acr_chain_props
`default_nettype wire

// ===== acr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module acr_host_model (
  input wire logic sys_clk_i,
  output var logic [2:0] reg_addr_o,
  output var logic reg_wr_o,
  output var logic reg_rd_o,
  output var acr_pkg::acr_byte_t reg_wdata_o
);
  import acr_pkg::*;
  initial begin
    reg_addr_o = 3'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // One strobe cycle per access; data bus scrambled when not writing
  task automatic xfer(input logic wr, input logic [2:0] a, input acr_byte_t d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = wr ? d : ~reg_wdata_o;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule // acr_host_model
`default_nettype wire

// ===== acr_chain_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module acr_chain_regs_tb;
  import acr_pkg::*;
  localparam int unsigned OSC = 20;
  localparam acr_byte_t DFLT [8] = '{8'h00, 8'h00, 8'h28, 8'hf1, 8'hc0, 8'h0c, 8'h00, 8'h00};
  localparam acr_byte_t RWM [8] = '{8'h00, 8'h00, 8'h7c, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h3f};
  localparam acr_byte_t CF [6] = '{8'h80, 8'ha0, 8'h80, 8'h80, 8'hc4, 8'he0};
  localparam logic [1:0] FSV [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
  localparam logic [1:0] MD [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2};
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wake_i = 1'b0;
  logic mod_bit_i = 1'b0;
  logic reg_wr_i, reg_rd_i, ref_sel_o, busy_o, chop_o, sample_tick_o, conv_done_o, osc_ready_o;
  logic stage1_gain_o;
  logic [2:0] reg_addr_i, oversample_ratio_sel_o;
  logic [1:0] elem_conv_count_sel_o, modulator_bias_scale_o, amplifier_bias_scale_o;
  logic [1:0] sample_rate_sel_o, stage2_gain_o;
  logic [3:0] stage_enable_o, stage2_offset_o;
  logic [6:0] stage3_gain_o, stage3_offset_o;
  logic [4:0] input_sel_o;
  acr_byte_t reg_wdata_i, reg_rdata_o;
  acr_byte_t exp_q [$];
  acr_byte_t sh [8];
  logic [1:0] rd_p = 2'b00;
  logic [1:0] md = 2'h0;
  int fail_count = 0;
  int n_tests = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  acr_host_model i_host (.sys_clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  acr_chain_regs #(.OSC_START_CYCLES(OSC)) i_dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .wake_i, .mod_bit_i, .elem_conv_count_sel_o,
    .oversample_ratio_sel_o, .modulator_bias_scale_o, .amplifier_bias_scale_o, .stage_enable_o,
    .sample_rate_sel_o, .stage1_gain_o, .stage2_gain_o, .stage2_offset_o, .stage3_gain_o,
    .stage3_offset_o, .input_sel_o, .ref_sel_o, .busy_o, .chop_o, .sample_tick_o,
    .conv_done_o, .osc_ready_o);
  // Modulator bit follows the chop phase, its inverse, or stays low
  always @(negedge sys_clk_i) mod_bit_i <= (md == 2'h0) ? 1'b0 : chop_o ^ md[1];
  task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input acr_byte_t got, input acr_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge sys_clk_i) rd_p <= {rd_p[0], reg_rd_i};
  always @(negedge sys_clk_i) begin
    if (rd_p[1] && exp_q.size() > 0) begin
      cmp_byte(reg_rdata_o, exp_q.pop_front());
    end
  end
  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input acr_byte_t d);
    i_host.xfer(1'b1, a, d);
    sh[a] = d & RWM[a];
  endtask
  task automatic rd(input logic [2:0] a, output acr_byte_t v);
    i_host.xfer(1'b0, a, 8'h00);
    @(negedge sys_clk_i);
    v = reg_rdata_o;
  endtask
  task automatic rx(input logic [2:0] a, input acr_byte_t e);
    acr_byte_t v;
    exp_q.push_back(e);
    rd(a, v);
  endtask
  task automatic chk_fields();
    cmp_val({elem_conv_count_sel_o, oversample_ratio_sel_o, modulator_bias_scale_o,
      amplifier_bias_scale_o, stage_enable_o, sample_rate_sel_o, stage2_gain_o, stage2_offset_o,
      stage1_gain_o, stage3_gain_o, stage3_offset_o, input_sel_o, ref_sel_o},
      {sh[2][6:2], sh[3], sh[4], sh[5], sh[6][6:0], sh[7][5:0]});
  endtask
  // Conversion of t sample periods of p cycles, within one period
  task automatic wait_done(input int t, input int p);
    int c;
    c = 0;
    while (conv_done_o !== 1'b1 && c < (t + 2) * p) begin
      @(negedge sys_clk_i);
      c++;
    end
    cmp_val(c >= (t - 1) * p && c <= (t + 1) * p, 1'b1);
    @(negedge sys_clk_i);
  endtask
  initial begin
    acr_byte_t v;
    logic [15:0] r;
    logic [15:0] f;
    int t;
    void'($urandom(32'h2d64));
    sh = DFLT;
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk_fields();
    for (int i = 0; i < 8; i++) rx(i[2:0], DFLT[i]);
    repeat (3) begin
      for (int i = 0; i < 8; i++) begin
        v = 8'($urandom());
        wr(i[2:0], i < 2 ? v : v & RWM[i]);
        chk_fields();
        rx(i[2:0], v & RWM[i]);
      end
    end
    for (int k = 0; k < 6; k++) begin
      wr(3'h4, {FSV[k], 6'h00});
      md = MD[k];
      wr(3'h2, CF[k]);
      t = (1 << CF[k][6:5]) * ((8 << CF[k][4:2]) + 1) + 1;
      wait_done(t, 200 << (3 - FSV[k]));
      rd(3'h0, v);
      r[15:8] = v;
      rd(3'h1, v);
      r[7:0] = v;
      if (k == 2) f = r;
      // Bits following chop give negative full scale, inverted bits positive; all-low bits cancel over chopped halves
      cmp_val(r, MD[k] == 2'h0 ? 16'h0 : {~MD[k][1], {15{MD[k][1]}}});
    end
    cmp_val(f, 16'h7fff);
    wr(3'h4, 8'hc0);
    wr(3'h2, 8'h80);
    wr(3'h2, 8'h80);
    cmp_val(busy_o, 1'b1);
    wait_done(10, 200);
    repeat (2) @(negedge sys_clk_i);
    cmp_val(busy_o, 1'b1);
    wait_done(10, 200);
    wr(3'h2, 8'h02);
    wait_done(10, 200);
    rx(3'h2, 8'h02);
    rx(3'h7, {2'b10, sh[7][5:0]});
    wait_done(10, 200);
    wr(3'h2, 8'h00);
    wait_done(10, 200);
    repeat (400) @(negedge sys_clk_i);
    cmp_val(busy_o, 1'b0);
    wr(3'h3, 8'h5a);
    wr(3'h2, 8'h84);
    wr(3'h7, 8'h55);
    sh = DFLT;
    chk_fields();
    cmp_val(busy_o, 1'b1);
    wait_done(67, 200);
    wake_i = 1'b1;
    @(negedge sys_clk_i);
    wake_i = 1'b0;
    wr(3'h2, 8'h80);
    repeat (4) @(negedge sys_clk_i);
    cmp_val({osc_ready_o, busy_o}, 2'b00);
    wait_done(10, 200);
    tally_and_finish();
  end
  initial begin
    repeat (95000) @(posedge sys_clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule // acr_chain_regs_tb
bind acr_chain_regs acr_chain_props #(.OSC_START_CYCLES(OSC_START_CYCLES)) i_props (.sys_clk_i,
  .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .elem_conv_count_sel_o,
  .oversample_ratio_sel_o, .sample_rate_sel_o, .stage1_gain_o, .stage3_gain_o, .busy_o, .chop_o,
  .sample_tick_o, .conv_done_o, .osc_ready_o);
`default_nettype wire
